// [srp_pkg.sv]
/*
  Constants for the spectral record processor: register byte addresses,
  field positions, reset values, codes and processing times.
  Assumes a 40 MHz core clock and 16-bit registers split into byte addresses.
*/
package srp_pkg;
  // Register byte addresses (low byte; high byte is +1)
  localparam logic [6:0] A_AVG_LO = 7'h0E;
  localparam logic [6:0] A_AVG_HI = 7'h10;
  localparam logic [6:0] A_REC_CTRL = 7'h1A;
  localparam logic [6:0] A_PERIOD = 7'h1E;
  localparam logic [6:0] A_ALARM = 7'h30;
  localparam logic [6:0] A_RATE = 7'h32;
  localparam logic [6:0] A_GCMD = 7'h36;
  localparam logic [6:0] A_BUF = 7'h42;
  localparam logic [6:0] A_WEAR = 7'h4A;
  localparam logic [6:0] A_CNT = 7'h50;
  // Reset values
  localparam logic [15:0] AVG_LO_RST = 16'h0108;
  localparam logic [15:0] AVG_HI_RST = 16'h0101;
  localparam logic [15:0] REC_CTRL_RST = 16'h0100;
  localparam logic [15:0] PERIOD_RST = 16'h0001;
  localparam logic [15:0] ALARM_RST = 16'h0080;
  localparam logic [15:0] RATE_RST = 16'h9630;
  // Field positions
  localparam int WIN_LSB = 12;
  localparam int EN_LSB = 8;
  localparam int STORE_LSB = 2;
  localparam int MODE_LSB = 0;
  localparam int ERASE_BIT = 0;
  localparam int START_BIT = 3;
  // Codes
  localparam logic [1:0] WIN_HANN = 2'h1;
  localparam logic [1:0] WIN_FLAT = 2'h2;
  localparam logic [1:0] ST_NONE = 2'h0;
  localparam logic [1:0] ST_ALARM = 2'h1;
  localparam logic [1:0] ST_ALL = 2'h2;
  localparam logic [1:0] MODE_AUTO = 2'h1;
  localparam logic [1:0] MODE_TIME = 2'h2;
  // Sizes
  localparam int REC_LEN = 512;
  localparam int BINS = 256;
  localparam logic [4:0] FLASH_RECS = 5'h0E;
  // Timing
  localparam int CLK_HZ = 40_000_000;
  localparam int BASE_SPS = 20_000;
  localparam int SAMPLE_DIV = CLK_HZ / BASE_SPS;
  localparam real T_PT_MS = 18.7;
  localparam real T_FFT_MS = 32.7;
  localparam real T_ST_MS = 120.0;
  localparam real T_AST_MS = 2.21;
  localparam int T_PT_CYC = int'($floor(T_PT_MS * CLK_HZ / 1000.0));
  localparam int T_FFT_CYC = int'($floor(T_FFT_MS * CLK_HZ / 1000.0));
  localparam int T_ST_CYC = int'($floor(T_ST_MS * CLK_HZ / 1000.0));
  localparam int T_AST_CYC = int'($floor(T_AST_MS * CLK_HZ / 1000.0));
  localparam int PERIOD_TICK = 40_000;
endpackage

// [srp_core.sv]
/*
  Spectral record processor: SPI register slave, sample FIFO, windowing,
  binned magnitude spectrum with averaging, flash record bookkeeping.
  Assumes samples arrive on core_clk and SPI pins are asynchronous.
*/
// Functional notes
// - Window select field picks rect, Hanning, flattop
// - 512 samples become 256 magnitude bins
// - Each rate option averages its own count
// - Low average register: option1 high, option0 low
// - High average register: option3 high, option2 low
// - Record time: N times sample, processing, transform
// - Storage time only when storage field nonzero
// - Alarm scan time only when alarms enabled
// - Finished spectrum lands in readable data buffer
// - Storage code 01 stores only on alarm
// - Storage code 10 stores every record set
// - Fourteen records; refuse storing when full
// - Record counter reports stored records, five bits
// - Global command bit 8 erases all records
// - Records split 14/7/4/3 among options
// - Auto mode steps all options unaided
// - Wear counter counts each full flash fill
// - Sample rate is 20000 over two^field, field capped at 10
`timescale 1ns/1ps
module srp_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  // Pointers wrap by overflow, so depth must be a power of two
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad
    $error("srp_fifo depth must be a power of two");
  end
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp_reg, rp_reg;
  logic [AW:0] cnt_reg;
  wire push = in_valid & in_ready;
  wire pop = out_valid & out_ready;
  wire [AW:0] cnt_next = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
  assign out_data = mem[rp_reg];
  // Flags registered from the next count, so they are honest every cycle
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_reg <= '0;
      wp_reg <= '0;
      rp_reg <= '0;
      in_ready <= 1'b0;
      out_valid <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      wp_reg <= wp_reg + AW'(push);
      rp_reg <= rp_reg + AW'(pop);
      in_ready <= cnt_next != (AW+1)'(DEPTH);
      out_valid <= cnt_next != '0;
    end
  end
  // Storage has no reset
  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wp_reg] <= in_data;
    end
  end
endmodule

module srp_core #(
  parameter int FIFO_DEPTH = 16,
  parameter int T_PT = srp_pkg::T_PT_CYC,
  parameter int T_FFT = srp_pkg::T_FFT_CYC,
  parameter int T_ST = srp_pkg::T_ST_CYC,
  parameter int T_AST = srp_pkg::T_AST_CYC,
  parameter int S_DIV = srp_pkg::SAMPLE_DIV,
  parameter int P_TICK = srp_pkg::PERIOD_TICK
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic spi_sclk,
  input wire logic spi_cs_b,
  input wire logic spi_mosi,
  output logic spi_miso,
  output logic spi_miso_oe,
  input wire logic sample_valid,
  input wire logic [15:0] sample_data,
  output logic sample_ready,
  input wire logic alarm_hit,
  output logic status_output_one
);
  // Wait counter is 23 bits wide
  if (T_ST >= 2**23 || T_PT + T_FFT >= 2**23 || S_DIV < 1 || S_DIV * 1024 >= 2**23) begin : g_bad
    $error("srp_core timing parameters out of range");
  end
  typedef enum logic [2:0] {IDLE, COLLECT, XFORM, STORE, SCAN} srp_state_e;
  srp_state_e st_reg;
  // Software registers
  logic [15:0] avg_lo_reg, avg_hi_reg, rec_ctrl_reg, period_reg, alarm_reg, rate_reg;
  logic [15:0] wear_reg;
  logic [4:0] rec_cnt_reg;
  logic [3:0] opt_cnt_reg [4];
  logic [15:0] buf_mem [srp_pkg::BINS];
  logic [7:0] buf_ptr_reg;

  // Pin synchronisers, third stage only for edge detection
  logic [2:0] sclk_q, cs_q;
  logic [1:0] mosi_q;
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      sclk_q <= 3'h7;
      cs_q <= 3'h7;
      mosi_q <= 2'h0;
    end else begin
      sclk_q <= {sclk_q[1:0], spi_sclk};
      cs_q <= {cs_q[1:0], spi_cs_b};
      mosi_q <= {mosi_q[0], spi_mosi};
    end
  end
  wire sclk_rise = sclk_q[1] & ~sclk_q[2];
  wire sclk_fall = ~sclk_q[1] & sclk_q[2];
  wire cs_fall = ~cs_q[1] & cs_q[2];
  wire cs_act = ~cs_q[1];

  // Frame shifter: 16 bits, MSB first; bit 15 set means write
  logic [15:0] rx_reg, tx_reg;
  logic [3:0] bit_reg;
  logic [6:0] rd_addr_reg;
  logic frame_done_reg;
  wire [15:0] rx_word = {rx_reg[14:0], mosi_q[1]};
  wire wr = frame_done_reg & rx_reg[15];
  wire rd = frame_done_reg & ~rx_reg[15];
  wire [6:0] wa = rx_reg[14:8];
  wire [7:0] wd = rx_reg[7:0];

  // Read decode, one 16-bit word per even address
  function automatic logic [15:0] reg_read(input logic [6:0] a, input logic [15:0] bw);
    unique case ({a[6:1], 1'b0})
      srp_pkg::A_AVG_LO: reg_read = avg_lo_reg;
      srp_pkg::A_AVG_HI: reg_read = avg_hi_reg;
      srp_pkg::A_REC_CTRL: reg_read = rec_ctrl_reg;
      srp_pkg::A_PERIOD: reg_read = period_reg;
      srp_pkg::A_ALARM: reg_read = alarm_reg;
      srp_pkg::A_RATE: reg_read = rate_reg;
      srp_pkg::A_BUF: reg_read = bw;
      srp_pkg::A_WEAR: reg_read = wear_reg;
      srp_pkg::A_CNT: reg_read = {11'h000, rec_cnt_reg};
      default: reg_read = 16'h0000;
    endcase
  endfunction

  // Word loaded at select; a buffer read advances the pointer as its word loads
  wire [15:0] rd_word = reg_read(rd_addr_reg, buf_mem[buf_ptr_reg]);
  wire buf_load = cs_fall & ({rd_addr_reg[6:1], 1'b0} == srp_pkg::A_BUF);

  // SPI shift: sample on rising edge, drive on falling edge
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_reg <= 16'h0000;
      tx_reg <= 16'h0000;
      bit_reg <= 4'h0;
      rd_addr_reg <= 7'h00;
      frame_done_reg <= 1'b0;
      spi_miso <= 1'b0;
      spi_miso_oe <= 1'b0;
    end else begin
      frame_done_reg <= cs_act & sclk_rise & (bit_reg == 4'hF);
      spi_miso_oe <= cs_act;
      if (cs_fall) begin
        bit_reg <= 4'h0;
        tx_reg <= rd_word;
        spi_miso <= rd_word[15];
      end else if (cs_act & sclk_rise) begin
        rx_reg <= rx_word;
        bit_reg <= bit_reg + 4'h1;
      end else if (cs_act & sclk_fall & (bit_reg != 4'h0)) begin
        // MSB already stands from select; the leading fall must not shift it
        tx_reg <= {tx_reg[14:0], 1'b0};
        spi_miso <= tx_reg[14];
      end
      if (rd) begin
        rd_addr_reg <= wa;
      end
    end
  end

  // Sample path through the FIFO; the engine stalls it between records
  logic fifo_valid, take_ok;
  logic [15:0] fifo_data;
  srp_fifo #(.WIDTH(16), .DEPTH(FIFO_DEPTH)) u_fifo (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .in_valid(sample_valid),
    .in_data(sample_data),
    .in_ready(sample_ready),
    .out_valid(fifo_valid),
    .out_data(fifo_data),
    .out_ready(take_ok)
  );

  // Next enabled option after cur (4 = none)
  function automatic logic [2:0] next_opt(input logic [3:0] en, input logic [2:0] cur);
    next_opt = 3'h4;
    for (int i = 3; i >= 0; i--) begin
      // A start value of 7 means no option yet, so every enabled one qualifies
      if (en[i] && (cur == 3'h7 || 3'(i) > cur)) begin
        next_opt = 3'(i);
      end
    end
  endfunction

  // Window gain out of 255, by sample index
  function automatic logic [7:0] win_gain(input logic [1:0] sel, input logic [8:0] idx);
    logic [7:0] d;
    d = idx[8] ? ~idx[7:0] : idx[7:0];
    unique case (sel)
      srp_pkg::WIN_HANN: win_gain = d;
      srp_pkg::WIN_FLAT: win_gain = (d < 8'h40) ? {d[5:0], 2'h3} : 8'hFF;
      default: win_gain = 8'hFF;
    endcase
  endfunction

  // Control fields
  wire [1:0] win_sel = rec_ctrl_reg[srp_pkg::WIN_LSB +: 2];
  wire [3:0] opt_en = rec_ctrl_reg[srp_pkg::EN_LSB +: 4];
  wire [1:0] store_sel = rec_ctrl_reg[srp_pkg::STORE_LSB +: 2];
  wire [1:0] mode = rec_ctrl_reg[srp_pkg::MODE_LSB +: 2];
  wire time_mode = mode == srp_pkg::MODE_TIME;

  logic [2:0] opt_reg;
  logic [7:0] avg_idx_reg;
  logic [8:0] smp_reg;
  logic [22:0] wait_reg;
  logic [22:0] pace_reg;
  logic [31:0] per_cnt_reg;
  logic alarm_seen_reg;
  wire [1:0] o = opt_reg[1:0];
  // Per-option average count, bytes laid out per register
  wire [7:0] n_raw = o[1] ? (o[0] ? avg_hi_reg[15:8] : avg_hi_reg[7:0])
                          : (o[0] ? avg_lo_reg[15:8] : avg_lo_reg[7:0]);
  wire [7:0] n_avg = time_mode ? 8'h01 : ((n_raw == 8'h00) ? 8'h01 : n_raw);
  wire [3:0] sr = rate_reg[o * 4 +: 4];
  wire [22:0] pace_len = 23'(S_DIV) << ((sr > 4'hA) ? 4'hA : sr);
  wire [2:0] n_sel = 3'(opt_en[0]) + 3'(opt_en[1]) + 3'(opt_en[2]) + 3'(opt_en[3]);
  wire [3:0] per_lim = (n_sel == 3'h1) ? 4'hE : (n_sel == 3'h2) ? 4'h7 : (n_sel == 3'h3) ? 4'h4 : 4'h3;
  wire want_store = (store_sel == srp_pkg::ST_ALL) | ((store_sel == srp_pkg::ST_ALARM) & alarm_seen_reg);
  wire room = (rec_cnt_reg < srp_pkg::FLASH_RECS) & (opt_cnt_reg[o] < per_lim);
  wire do_store = want_store & room;
  wire alarms_on = alarm_reg[3:0] != 4'h0;
  wire [2:0] first_opt = next_opt(opt_en, 3'h7);
  wire [2:0] after_opt = next_opt(opt_en, opt_reg);
  wire erase_cmd = wr & (wa == srp_pkg::A_GCMD + 7'h1) & wd[srp_pkg::ERASE_BIT];
  wire start_man = wr & (wa == srp_pkg::A_GCMD + 7'h1) & wd[srp_pkg::START_BIT];
  wire period_hit = per_cnt_reg >= 32'(period_reg) * 32'(P_TICK);
  wire start_auto = (mode == srp_pkg::MODE_AUTO) & period_hit;
  wire wait_done = wait_reg == 23'h0;
  assign take_ok = (st_reg == COLLECT) & (pace_reg == 23'h0);
  wire take = take_ok & fifo_valid;
  // Magnitude of windowed sample, scaled by the average count
  wire [15:0] s_abs = fifo_data[15] ? 16'(-fifo_data) : fifo_data;
  wire [23:0] s_win = 24'(s_abs) * 24'(win_gain(win_sel, smp_reg));
  wire [15:0] contrib = 16'((s_win >> 8) / 24'(n_avg));
  wire [7:0] bin = smp_reg[8:1];
  wire fresh = (avg_idx_reg == 8'h00) & ~smp_reg[0];
  wire [16:0] bin_sum = 17'(fresh ? 16'h0000 : buf_mem[bin]) + 17'(contrib);

  // Register writes, byte addressed
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      avg_lo_reg <= srp_pkg::AVG_LO_RST;
      avg_hi_reg <= srp_pkg::AVG_HI_RST;
      rec_ctrl_reg <= srp_pkg::REC_CTRL_RST;
      period_reg <= srp_pkg::PERIOD_RST;
      alarm_reg <= srp_pkg::ALARM_RST;
      rate_reg <= srp_pkg::RATE_RST;
    end else if (wr) begin
      unique case ({wa[6:1], 1'b0})
        srp_pkg::A_AVG_LO: avg_lo_reg[wa[0]*8 +: 8] <= wd;
        srp_pkg::A_AVG_HI: avg_hi_reg[wa[0]*8 +: 8] <= wd;
        srp_pkg::A_REC_CTRL: rec_ctrl_reg[wa[0]*8 +: 8] <= wd;
        srp_pkg::A_PERIOD: period_reg[wa[0]*8 +: 8] <= wd;
        srp_pkg::A_ALARM: alarm_reg[wa[0]*8 +: 8] <= wd;
        srp_pkg::A_RATE: rate_reg[wa[0]*8 +: 8] <= wd;
        default: ;
      endcase
    end
  end

  // Spectrum buffer update, one bin per sample pair
  always_ff @(posedge core_clk) begin
    if (take) begin
      buf_mem[bin] <= bin_sum[16] ? 16'hFFFF : bin_sum[15:0];
    end
  end

  // Record engine
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_reg <= IDLE;
      opt_reg <= 3'h0;
      avg_idx_reg <= 8'h00;
      smp_reg <= 9'h000;
      wait_reg <= 23'h0;
      pace_reg <= 23'h0;
      per_cnt_reg <= 32'h0;
      alarm_seen_reg <= 1'b0;
      rec_cnt_reg <= 5'h00;
      wear_reg <= 16'h0000;
      opt_cnt_reg <= '{4{4'h0}};
      buf_ptr_reg <= 8'h00;
      status_output_one <= 1'b0;
    end else begin
      status_output_one <= st_reg != IDLE;
      per_cnt_reg <= (st_reg == IDLE && start_auto) ? 32'h0 : per_cnt_reg + 32'h1;
      wait_reg <= wait_done ? 23'h0 : wait_reg - 23'h1;
      pace_reg <= take ? pace_len - 23'h1 : (pace_reg == 23'h0 ? 23'h0 : pace_reg - 23'h1);
      alarm_seen_reg <= alarm_seen_reg | alarm_hit;
      if (buf_load) begin
        buf_ptr_reg <= buf_ptr_reg + 8'h01;
      end
      if (erase_cmd) begin
        rec_cnt_reg <= 5'h00;
        opt_cnt_reg <= '{4{4'h0}};
      end
      unique case (st_reg)
        IDLE: if ((start_man | start_auto) && first_opt != 3'h4) begin
          st_reg <= COLLECT;
          opt_reg <= first_opt;
          avg_idx_reg <= 8'h00;
          smp_reg <= 9'h000;
          alarm_seen_reg <= alarm_hit;
        end
        COLLECT: if (take) begin
          smp_reg <= smp_reg + 9'h001;
          if (smp_reg == 9'(srp_pkg::REC_LEN - 1)) begin
            st_reg <= XFORM;
            wait_reg <= time_mode ? 23'(T_PT) : 23'(T_PT + T_FFT);
          end
        end
        XFORM: if (wait_done) begin
          if (avg_idx_reg + 8'h01 < n_avg) begin
            avg_idx_reg <= avg_idx_reg + 8'h01;
            st_reg <= COLLECT;
          end else begin
            buf_ptr_reg <= 8'h00;
            st_reg <= STORE;
            wait_reg <= (store_sel != srp_pkg::ST_NONE) ? 23'(T_ST) : 23'h0;
          end
        end
        STORE: if (wait_done) begin
          if (do_store && !erase_cmd) begin
            rec_cnt_reg <= rec_cnt_reg + 5'h01;
            opt_cnt_reg[o] <= opt_cnt_reg[o] + 4'h1;
            if (rec_cnt_reg == srp_pkg::FLASH_RECS - 5'h01) begin
              wear_reg <= wear_reg + 16'h0001;
            end
          end
          st_reg <= SCAN;
          wait_reg <= alarms_on ? 23'(T_AST) : 23'h0;
        end
        SCAN: if (wait_done) begin
          if (after_opt != 3'h4) begin
            st_reg <= COLLECT;
            opt_reg <= after_opt;
            avg_idx_reg <= 8'h00;
            smp_reg <= 9'h000;
            alarm_seen_reg <= alarm_hit;
          end else begin
            st_reg <= IDLE;
          end
        end
      endcase
    end
  end

  // Checks
  property p_store_none;
    @(posedge core_clk) disable iff (!rst_b)
    (st_reg == STORE && store_sel == srp_pkg::ST_NONE && !erase_cmd) |=> $stable(rec_cnt_reg) && $stable(wear_reg);
  endproperty
  a_store_none: assert property (p_store_none) else $error("counters moved with storage off");
  property p_cap;
    @(posedge core_clk) disable iff (!rst_b) rec_cnt_reg <= srp_pkg::FLASH_RECS;
  endproperty
  a_cap: assert property (p_cap) else $error("record count past capacity");
  property p_erase;
    @(posedge core_clk) disable iff (!rst_b) erase_cmd |=> rec_cnt_reg == 5'h00;
  endproperty
  a_erase: assert property (p_erase) else $error("erase left records");
  property p_wear;
    @(posedge core_clk) disable iff (!rst_b)
    (wear_reg != $past(wear_reg)) |-> (rec_cnt_reg == srp_pkg::FLASH_RECS && wear_reg == $past(wear_reg) + 16'h1);
  endproperty
  a_wear: assert property (p_wear) else $error("wear count step wrong");
  property p_xform_len;
    @(posedge core_clk) disable iff (!rst_b)
    (st_reg == COLLECT && take && smp_reg == 9'h1FF) |=> wait_reg == (time_mode ? 23'(T_PT) : 23'(T_PT + T_FFT));
  endproperty
  a_xform_len: assert property (p_xform_len) else $error("processing wait wrong");
  property p_store_time;
    @(posedge core_clk) disable iff (!rst_b)
    (st_reg == XFORM && wait_done && avg_idx_reg + 8'h01 >= n_avg) |=>
      (st_reg == STORE && wait_reg == ((store_sel != srp_pkg::ST_NONE) ? 23'(T_ST) : 23'h0));
  endproperty
  a_store_time: assert property (p_store_time) else $error("storage time wrong");
  property p_scan_time;
    @(posedge core_clk) disable iff (!rst_b)
    (st_reg == STORE && wait_done) |=> (st_reg == SCAN && (wait_reg != 23'h0) == alarms_on);
  endproperty
  a_scan_time: assert property (p_scan_time) else $error("alarm scan time wrong");
  property p_alarm_store;
    @(posedge core_clk) disable iff (!rst_b)
    (st_reg == STORE && wait_done && store_sel == srp_pkg::ST_ALARM && !alarm_seen_reg) |=> $stable(rec_cnt_reg);
  endproperty
  a_alarm_store: assert property (p_alarm_store) else $error("stored without alarm");
  property p_pace;
    @(posedge core_clk) disable iff (!rst_b) take |=> pace_reg == pace_len - 23'h1;
  endproperty
  a_pace: assert property (p_pace) else $error("sample pacing wrong");
  c_record: cover property (@(posedge core_clk) disable iff (!rst_b) st_reg == STORE && wait_done && do_store);
  c_average: cover property (@(posedge core_clk) disable iff (!rst_b) st_reg == XFORM ##1 st_reg == COLLECT);
  c_full: cover property (@(posedge core_clk) disable iff (!rst_b) rec_cnt_reg == srp_pkg::FLASH_RECS);
endmodule

// [srp_host_model.sv]
/*
  Host-side SPI master model for the spectral record processor.
  Assumes mode 3 framing and a core clock much faster than sclk.
*/
`timescale 1ns/1ps
module srp_host_model (
  input wire logic core_clk,
  output logic spi_sclk,
  output logic spi_cs_b,
  output logic spi_mosi,
  input wire logic spi_miso,
  output logic rd_valid,
  output logic [15:0] rd_data
);
  // Idle: clock high, deselected
  initial begin
    spi_sclk = 1'b1;
    spi_cs_b = 1'b1;
    spi_mosi = 1'b0;
    rd_valid = 1'b0;
    rd_data = 16'h0000;
  end
  // Wait whole core cycles
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  // One frame, MSB first; half period of 6 clocks clears the 4-clock floor
  // Frames stay apart and the auto period is never programmed short
  task automatic frame(input logic [15:0] tx, output logic [15:0] rx);
    spi_cs_b <= 1'b0;
    tick(6);
    for (int i = 15; i >= 0; i--) begin
      spi_sclk <= 1'b0;
      spi_mosi <= tx[i];
      tick(6);
      rx[i] = spi_miso;
      spi_sclk <= 1'b1;
      tick(6);
    end
    spi_cs_b <= 1'b1;
    // Released line shows the inverse, never a stale bit
    spi_mosi <= ~tx[0];
    tick(6);
  endtask
  // Hand a read word to the watcher for one cycle
  task automatic post(input logic [15:0] w);
    rd_data <= w;
    rd_valid <= 1'b1;
    tick(1);
    rd_valid <= 1'b0;
  endtask
endmodule

// [spectral_record_processor_tb.sv]
/*
  Self-checking bench for srp_core: registers over SPI, sample FIFO,
  timing of optional steps, flash record counting and erase.
  Assumes shortened processing parameters and the host model.
*/
`timescale 1ns/1ps
module spectral_record_processor_tb;
  localparam int TST = 40;
  localparam int TAST = 10;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic spi_sclk, spi_cs_b, spi_mosi, spi_miso, spi_miso_oe;
  logic sample_valid = 1'b0;
  logic [15:0] sample_data = 16'h0000;
  logic sample_ready;
  logic alarm_hit = 1'b0;
  logic busy;
  logic rd_valid;
  logic [15:0] rd_data, rx, v;
  logic [15:0] exp_q[$]; // Expected read words, oldest first
  logic [15:0] smp_q[$]; // Accepted samples, oldest first
  int num_errors = 0;
  int total_checks = 0;
  int seed = 22507;
  int taken = 0; // Samples accepted by the FIFO
  bit feed = 0; // Sample source on or off
  int d0, d1;
  // 40 MHz core clock
  always #12.5 core_clk = ~core_clk;
  srp_core #(.T_PT(20), .T_FFT(30), .T_ST(TST), .T_AST(TAST), .S_DIV(2), .P_TICK(4)) srp_core_i (
    .core_clk(core_clk), .rst_b(rst_b), .spi_sclk(spi_sclk), .spi_cs_b(spi_cs_b),
    .spi_mosi(spi_mosi), .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe),
    .sample_valid(sample_valid), .sample_data(sample_data), .sample_ready(sample_ready),
    .alarm_hit(alarm_hit), .status_output_one(busy));
  srp_host_model srp_host_model_i (.core_clk(core_clk), .spi_sclk(spi_sclk), .spi_cs_b(spi_cs_b),
    .spi_mosi(spi_mosi), .spi_miso(spi_miso), .rd_valid(rd_valid), .rd_data(rd_data));
  // Sample source: data held until taken, random otherwise
  always @(posedge core_clk) begin
    if (sample_valid && sample_ready) begin
      taken <= taken + 1;
      smp_q.push_back(sample_data);
    end
    if (!sample_valid || sample_ready) begin
      sample_valid <= feed;
      sample_data <= 16'($random(seed));
    end
  end
  // Compare one value and count it
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    total_checks++;
    if (seen !== want) begin
      num_errors++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, want);
    end
  endtask
  // Rectangular window bin part: |s| at full gain of 255, shifted by 8
  function automatic logic [15:0] mag(input logic [15:0] s);
    logic [23:0] a;
    a = 24'(s[15] ? 16'(-s) : s) * 24'h0000FF;
    mag = 16'(a >> 8);
  endfunction
  // Watcher: every read word meets the oldest note
  always @(posedge core_clk) begin
    if (rd_valid === 1'b1) begin
      check(rd_data, exp_q.pop_front());
      check({15'h0000, spi_miso_oe}, 16'h0000);
    end
  end
  // Byte write frame
  task automatic wb(input logic [6:0] a, input logic [7:0] b);
    srp_host_model_i.frame({1'b1, a, b}, rx);
  endtask
  // Word write as two byte frames, low then high
  task automatic wr(input logic [6:0] a, input logic [15:0] w);
    wb(a, w[7:0]);
    wb(a + 7'h01, w[15:8]);
  endtask
  // Word read; the answer arrives in the following frame
  task automatic rd(input logic [6:0] a, input logic [15:0] want);
    exp_q.push_back(want);
    srp_host_model_i.frame({1'b0, a, 8'h00}, rx);
    srp_host_model_i.frame({1'b0, 7'h7E, 8'h00}, rx);
    srp_host_model_i.post(rx);
  endtask
  // Record counter read
  task automatic cnt(input logic [15:0] want);
    rd(srp_pkg::A_CNT, want);
  endtask
  // Start one engine pass and time the busy level
  task automatic run(output int dur);
    wb(srp_pkg::A_GCMD + 7'h01, 8'h08);
    check({15'h0000, busy}, 16'h0001);
    dur = 0;
    while (busy === 1'b1 && dur < 30000) begin
      @(posedge core_clk);
      dur++;
    end
    // A stuck engine counts against the run
    if (dur >= 30000) begin
      num_errors++;
    end
  endtask
  // Counts, verdict, end of run
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // Watchdog sized well above the expected run
  initial begin
    repeat (95000) @(posedge core_clk);
    num_errors++;
    tally_and_finish;
  end
  // Main sequence
  initial begin
    repeat (20) @(posedge core_clk);
    rst_b <= 1'b1;
    repeat (5) @(posedge core_clk);
    rd(srp_pkg::A_AVG_LO, 16'h0108);
    rd(srp_pkg::A_AVG_HI, 16'h0101);
    cnt(16'h0000);
    rd(srp_pkg::A_WEAR, 16'h0000);
    v = 16'($random(seed));
    wr(srp_pkg::A_AVG_LO, v);
    rd(srp_pkg::A_AVG_LO, v);
    v = 16'($random(seed));
    wr(srp_pkg::A_AVG_HI, v);
    rd(srp_pkg::A_AVG_HI, v);
    wr(srp_pkg::A_CNT, 16'h00FF);
    cnt(16'h0000);
    rd(7'h7C, 16'h0000);
    $display("register test done");
    // Idle engine: FIFO fills to its depth and refuses
    feed = 1;
    repeat (60) @(posedge core_clk);
    check(16'(taken), 16'h0010);
    check({15'h0000, sample_ready}, 16'h0000);
    $display("fifo test done");
    // Fast rate, one average, option 0 only, no storage, rectangular
    wr(srp_pkg::A_RATE, 16'h0000);
    wr(srp_pkg::A_AVG_LO, 16'h0101);
    wr(srp_pkg::A_REC_CTRL, 16'h0100);
    run(d0);
    cnt(16'h0000);
    rd(srp_pkg::A_WEAR, 16'h0000);
    // First record's samples 0 and 1 land in bin 0
    rd(srp_pkg::A_BUF, mag(smp_q[0]) + mag(smp_q[1]));
    wr(srp_pkg::A_AVG_LO, 16'h0102);
    run(d1);
    check(16'(d1 - d0), 16'(2 * 512 + 20 + 30));
    // Time mode: no transform wait, no averaging even with two set
    wb(srp_pkg::A_REC_CTRL, 8'h02);
    run(d1);
    check(16'(d0 - d1), 16'h001E);
    wb(srp_pkg::A_REC_CTRL, 8'h00);
    wr(srp_pkg::A_AVG_LO, 16'h0101);
    wr(srp_pkg::A_ALARM, 16'h0001);
    run(d1);
    check(16'(d1 - d0), 16'(TAST));
    wr(srp_pkg::A_ALARM, 16'h0000);
    $display("timing test done");
    // Store on alarm: time spent either way, record only with alarm
    wr(srp_pkg::A_REC_CTRL, 16'h0104);
    run(d1);
    check(16'(d1 - d0), 16'(TST));
    cnt(16'h0000);
    alarm_hit <= 1'b1;
    run(d1);
    alarm_hit <= 1'b0;
    cnt(16'h0001);
    // Store every set, Hanning window, fill all slots then overflow
    wr(srp_pkg::A_REC_CTRL, 16'h1108);
    for (int k = 2; k <= 15; k++) begin
      run(d1);
    end
    cnt(16'h000E);
    rd(srp_pkg::A_WEAR, 16'h0001);
    $display("storage test done");
    // Erase command word clears the record count
    wb(srp_pkg::A_GCMD + 7'h01, 8'h01);
    cnt(16'h0000);
    // Two options, flat top: one pass stores one record per option
    wr(srp_pkg::A_REC_CTRL, 16'h2308);
    run(d1);
    cnt(16'h0002);
    $display("erase test done");
    // Auto mode: period well above one two-option pass, no start command
    wr(srp_pkg::A_PERIOD, 16'h0400);
    wb(srp_pkg::A_REC_CTRL, 8'h09);
    repeat (3000) @(posedge core_clk);
    check({15'h0000, busy}, 16'h0000);
    wb(srp_pkg::A_REC_CTRL, 8'h08);
    cnt(16'h0004);
    $display("auto test done");
    tally_and_finish;
  end
endmodule
